// ### rtl/cid_pkg.sv
// Purpose: Shared constants and types for the CPU instruction decoder.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Printed offsets are register indices; the byte address is four times the index.
// Overview of operation
// - Each instruction is one to three bytes; opcode fetched first, then operands.
// - ADD at 28-2F,25,26-27,24; ADDC at 38-3F,35,36-37,34; two cycles.
// - SUBB at 98-9F, 95, 96-97 and 94, two cycles each.
// - Long-divide bit picks 16/16 or 32/16 divide, only in wide mode.
// - Narrow mode gives 8x8 multiply A4, 8/8 divide 84; cycles vary by mode.
// - AND at 58-5F,55,56-57,54 and 52,53; 53 is three bytes, four cycles.
// - OR at 48-4F,45,46-47,44 and 42,43; 43 is three bytes, four cycles.
// - XOR at 68-6F,65,66-67,64 and 62,63; 63 is three bytes, four cycles.
// - Rotates 23,33,03,13 one byte two cycles; clear E4, complement F4, swap C4.
// - Moves into accumulator at E8-EF, E5, E6-E7 and 74, two cycles.
// - Moves into register: F8-FF two, A8-AF four, 78-7F two cycles.
// - Moves to direct: F5 two cycles; 88-8F,85,86-87,75 four; 85,75 three bytes.
// - Indirect stores F6-F7 and 76-77 two cycles, A6-A7 four cycles.
// - Pointer load 90 three bytes four cycles; code reads 93 and 83 four cycles.
// - External moves one byte four cycles: reads E2-E3,E0; writes F2-F3,F0.
// - Push C0 and pop D0 are two bytes and four cycles.
// - Exchanges C8-CF, C5, C6-C7 and nibble exchange D6-D7, two cycles.
// - Eight-code ranges take the register number from the low three opcode bits.
// - Absolute jump and call codes give the top three opcode bits as address bits.
package cid_pkg;

   localparam int          ADDR_W         = 10;
   // Register indices.
   localparam logic [7:0]  IDX_CTRL       = 8'h00;
   localparam logic [7:0]  IDX_STATUS     = 8'h01;
   localparam logic [7:0]  IDX_OPERAND    = 8'h02;
   localparam logic [7:0]  IDX_PC         = 8'h03;
   localparam logic [7:0]  IDX_MD_OPERAND = 8'hF0;
   localparam logic [7:0]  IDX_CFG_LOW    = 8'hF6;
   // Reset values.
   localparam logic [7:0]  RST_MD_OPERAND = 8'h00;
   localparam logic [7:0]  RST_CFG_LOW    = 8'h00;
   localparam logic [15:0] RST_PC         = 16'h0000;
   // Field positions.
   localparam int          CTRL_RUN_BIT   = 0;
   localparam int          CFG_WIDE_BIT   = 0;
   localparam int          CFG_LONG_BIT   = 3;
   localparam int          ST_BUSY_BIT    = 0;
   localparam int          ST_ILLEGAL_BIT = 1;
   localparam int          ST_LEN_LSB     = 2;
   localparam int          ST_CYC_LSB     = 4;
   localparam int          ST_CLASS_LSB   = 10;
   localparam int          ST_REG_LSB     = 14;
   localparam int          ST_ATOP_LSB    = 17;
   localparam int          ST_OPC_LSB     = 24;
   // Lengths and cycle counts.
   localparam logic [1:0]  LEN_1          = 2'h1;
   localparam logic [1:0]  LEN_2          = 2'h2;
   localparam logic [1:0]  LEN_3          = 2'h3;
   localparam logic [5:0]  CYC_2          = 6'h02;
   localparam logic [5:0]  CYC_4          = 6'h04;
   localparam logic [5:0]  CYC_8          = 6'h08;
   localparam logic [5:0]  CYC_16         = 6'h10;
   localparam logic [5:0]  CYC_32         = 6'h20;
   localparam logic [5:0]  CYC_MAX        = 6'h3F;

   typedef enum logic [3:0]
   {
      CLS_ILLEGAL,
      CLS_ARITH,
      CLS_LOGIC,
      CLS_ROTATE,
      CLS_MOVE,
      CLS_EXTERNAL,
      CLS_STACK,
      CLS_EXCHANGE,
      CLS_MULDIV,
      CLS_ABS_JUMP
   } cid_class_type;

   typedef struct packed
   {
      logic          illegal;
      logic [1:0]    length;
      logic [5:0]    cycles;
      cid_class_type cls;
      logic [2:0]    reg_num;
      logic [2:0]    addr_top;
      logic [2:0]    mul_div_mode;
   } cid_decode_type;

   // Multiply/divide mode codes.
   localparam logic [2:0]  MD_NONE        = 3'h0;
   localparam logic [2:0]  MD_MUL_8X8     = 3'h1;
   localparam logic [2:0]  MD_MUL_16X16   = 3'h2;
   localparam logic [2:0]  MD_DIV_8_8     = 3'h3;
   localparam logic [2:0]  MD_DIV_16_16   = 3'h4;
   localparam logic [2:0]  MD_DIV_32_16   = 3'h5;

endpackage : cid_pkg

// ### rtl/cid_opcode_table.sv
// Purpose: Combinational opcode table giving length, cycles and class.
// Assumes: Mode bits are stable while an opcode is being looked up.
// Notes: Boolean and branch opcodes other than absolute jumps decode as illegal.
`timescale 1ns/1ps
module cid_opcode_table
   import cid_pkg::*;
(
   // Lookup.
   input  wire logic [7:0]     opcode,
   input  wire logic           wide_muldiv_enable,
   input  wire logic           long_dividend_select,
   // Result.
   output cid_decode_type      dec
);

   logic [3:0] hi;
   logic [3:0] lo;
   logic [1:0] acc_len;

   assign hi = opcode[7:4];
   assign lo = opcode[3:0];
   // Immediate and direct forms carry one operand byte, register and indirect none.
   assign acc_len = (lo == 4'h4 || lo == 4'h5) ? LEN_2 : LEN_1;

   always_comb
   begin
      dec = '{illegal: 1'b1, length: LEN_1, cycles: CYC_2, cls: CLS_ILLEGAL,
              reg_num: 3'h0, addr_top: 3'h0, mul_div_mode: MD_NONE};
      if (lo[3])
      begin
         dec.reg_num = opcode[2:0];
      end
      else
      begin
         dec.reg_num = {2'h0, opcode[0]};
      end
      if (opcode[3:0] == 4'h1)
      begin
         dec = '{illegal: 1'b0, length: LEN_2, cycles: CYC_4, cls: CLS_ABS_JUMP,
                 reg_num: 3'h0, addr_top: opcode[7:5], mul_div_mode: MD_NONE};
      end
      else if (lo >= 4'h4)
      begin
         case (hi)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h9:
            begin
               dec.illegal = 1'b0;
               dec.cls     = CLS_ARITH;
               dec.length  = (hi <= 4'h1 && lo == 4'h4) ? LEN_1 : acc_len;
            end
            4'h4, 4'h5, 4'h6:
            begin
               dec.illegal = 1'b0;
               dec.cls     = CLS_LOGIC;
               dec.length  = acc_len;
            end
            4'hE:
            begin
               dec.illegal = 1'b0;
               dec.cls     = (lo == 4'h4) ? CLS_LOGIC : CLS_MOVE;
               dec.length  = (lo == 4'h4) ? LEN_1 : acc_len;
            end
            4'hF:
            begin
               dec.illegal = 1'b0;
               dec.cls     = (lo == 4'h4) ? CLS_LOGIC : CLS_MOVE;
               dec.length  = (lo == 4'h5) ? LEN_2 : LEN_1;
            end
            4'hC:
            begin
               dec.illegal = 1'b0;
               dec.cls     = (lo == 4'h4) ? CLS_LOGIC : CLS_EXCHANGE;
               // The nibble swap at x4 is one byte; only the direct exchange carries an operand.
               dec.length  = (lo == 4'h5) ? LEN_2 : LEN_1;
            end
            4'h7:
            begin
               dec.illegal = 1'b0;
               dec.cls     = CLS_MOVE;
               dec.length  = (lo == 4'h5) ? LEN_3 : LEN_2;
               dec.cycles  = (lo == 4'h5) ? CYC_4 : CYC_2;
            end
            4'h8, 4'hA:
            begin
               if (lo == 4'h4)
               begin
                  dec.illegal = 1'b0;
                  dec.cls     = CLS_MULDIV;
                  if (hi == 4'hA)
                  begin
                     dec.cycles       = wide_muldiv_enable ? CYC_16 : CYC_8;
                     dec.mul_div_mode = wide_muldiv_enable ? MD_MUL_16X16 : MD_MUL_8X8;
                  end
                  else if (!wide_muldiv_enable)
                  begin
                     dec.cycles       = CYC_8;
                     dec.mul_div_mode = MD_DIV_8_8;
                  end
                  else
                  begin
                     dec.cycles       = long_dividend_select ? CYC_32 : CYC_16;
                     dec.mul_div_mode = long_dividend_select ? MD_DIV_32_16 : MD_DIV_16_16;
                  end
               end
               else if (!(hi == 4'hA && lo == 4'h5))
               begin
                  dec.illegal = 1'b0;
                  dec.cls     = CLS_MOVE;
                  dec.length  = (lo == 4'h5) ? LEN_3 : LEN_2;
                  dec.cycles  = CYC_4;
               end
            end
            4'hD:
            begin
               if (lo == 4'h4 || lo == 4'h6 || lo == 4'h7)
               begin
                  dec.illegal = 1'b0;
                  dec.cls     = (lo == 4'h4) ? CLS_ARITH : CLS_EXCHANGE;
               end
            end
            default:
            begin
               dec.illegal = 1'b1;
            end
         endcase
      end
      else if (lo == 4'h3 && hi <= 4'h3)
      begin
         dec.illegal = 1'b0;
         dec.cls     = CLS_ROTATE;
      end
      else if ((lo == 4'h2 || lo == 4'h3) && hi >= 4'h4 && hi <= 4'h6)
      begin
         dec.illegal = 1'b0;
         dec.cls     = CLS_LOGIC;
         dec.length  = (lo == 4'h3) ? LEN_3 : LEN_2;
         dec.cycles  = (lo == 4'h3) ? CYC_4 : CYC_2;
      end
      else if ((hi == 4'hE || hi == 4'hF) && lo != 4'h1)
      begin
         dec.illegal = 1'b0;
         dec.cls     = CLS_EXTERNAL;
         dec.cycles  = CYC_4;
      end
      else if ((hi == 4'hC || hi == 4'hD) && lo == 4'h0)
      begin
         dec.illegal = 1'b0;
         dec.cls     = CLS_STACK;
         dec.length  = LEN_2;
         dec.cycles  = CYC_4;
      end
      else if ((hi == 4'h9 && (lo == 4'h0 || lo == 4'h3)) || (hi == 4'h8 && lo == 4'h3)
               || (hi == 4'hA && lo == 4'h3))
      begin
         dec.illegal = 1'b0;
         dec.cls     = (hi == 4'hA) ? CLS_ARITH : CLS_MOVE;
         dec.length  = (hi == 4'h9 && lo == 4'h0) ? LEN_3 : LEN_1;
         dec.cycles  = CYC_4;
      end
   end

endmodule : cid_opcode_table

// ### rtl/cid_decoder.sv
// Purpose: Instruction fetch sequencer and decoder with an APB register file.
// Assumes: Program memory answers fetch_req with fetch_valid on the same clock.
// Notes: Illegal opcodes retire as one byte, two cycles, and are flagged.
`timescale 1ns/1ps
module cid_decoder
   import cid_pkg::*;
(
   // Clock and reset.
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata_q,
   output logic                   pready_q,
   output logic                   pslverr_q,
   // Program memory fetch.
   output logic                   fetch_req_q,
   output logic      [15:0]       fetch_addr_q,
   input  wire logic              fetch_valid,
   input  wire logic [7:0]        fetch_data,
   // Decoded instruction.
   output logic                   insn_valid_q,
   output logic      [7:0]        insn_opcode_q,
   output logic      [15:0]       insn_operand_q,
   output cid_decode_type         insn_dec_q
);

   typedef enum logic [1:0] {S_IDLE, S_OPCODE, S_OPERAND, S_EXEC} cid_state_type;

   cid_state_type  state_q;
   cid_decode_type dec_d;
   cid_decode_type dec_q;
   logic [7:0]     opcode_q;
   logic [15:0]    operand_q;
   logic [1:0]     bytes_left_q;
   logic [5:0]     cyc_q;
   logic           run_q;
   logic [7:0]     md_operand_q;
   logic [7:0]     cfg_low_q;
   logic           accept;
   logic           retire;
   logic           access;
   logic           wr_en;
   logic           addr_ok;
   logic [7:0]     idx;
   logic [31:0]    rd_value;

   cid_opcode_table u_table
   (
      .opcode               (fetch_data),
      .wide_muldiv_enable   (cfg_low_q[CFG_WIDE_BIT]),
      .long_dividend_select (cfg_low_q[CFG_LONG_BIT]),
      .dec                  (dec_d)
   );

   assign accept = fetch_req_q && fetch_valid;
   // The instruction ends once all bytes are in and its cycle budget is spent.
   assign retire = (state_q == S_EXEC) && (cyc_q >= (dec_q.cycles - 6'h01));

   // APB decode; writes land only on the edge that samples pready high.
   assign idx    = paddr[9:2];
   assign access = psel && penable;
   assign wr_en  = access && pready_q && pwrite && addr_ok;
   always_comb
   begin
      addr_ok  = (paddr[1:0] == 2'h0);
      rd_value = 32'h0000_0000;
      case (idx)
         IDX_CTRL:       rd_value[CTRL_RUN_BIT] = run_q;
         IDX_STATUS:
         begin
            rd_value[ST_BUSY_BIT]                = (state_q != S_IDLE);
            rd_value[ST_ILLEGAL_BIT]             = insn_dec_q.illegal;
            rd_value[ST_LEN_LSB +: 2]            = insn_dec_q.length;
            rd_value[ST_CYC_LSB +: 6]            = insn_dec_q.cycles;
            rd_value[ST_CLASS_LSB +: 4]          = insn_dec_q.cls;
            rd_value[ST_REG_LSB +: 3]            = insn_dec_q.reg_num;
            rd_value[ST_ATOP_LSB +: 3]           = insn_dec_q.addr_top;
            rd_value[ST_OPC_LSB +: 8]            = insn_opcode_q;
         end
         IDX_OPERAND:    rd_value[15:0] = insn_operand_q;
         IDX_PC:         rd_value[15:0] = fetch_addr_q;
         IDX_MD_OPERAND: rd_value[7:0]  = md_operand_q;
         IDX_CFG_LOW:    rd_value[7:0]  = cfg_low_q;
         default:        addr_ok = 1'b0;
      endcase
   end

   // One wait state: the answer is registered in the first access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else if (access && !pready_q)
      begin
         pready_q  <= 1'b1;
         pslverr_q <= !addr_ok;
         prdata_q  <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_value;
      end
      else
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_q        <= 1'b0;
         md_operand_q <= RST_MD_OPERAND;
         cfg_low_q    <= RST_CFG_LOW;
      end
      else if (wr_en && pstrb[0])
      begin
         if (idx == IDX_CTRL)
         begin
            run_q <= pwdata[CTRL_RUN_BIT];
         end
         if (idx == IDX_MD_OPERAND)
         begin
            md_operand_q <= pwdata[7:0];
         end
         // Mode bits are sampled at opcode fetch, so a change never alters a running count.
         if (idx == IDX_CFG_LOW)
         begin
            cfg_low_q <= pwdata[7:0];
         end
      end
   end

   // Sequencer: opcode, then listed operand bytes, then the remaining cycles.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q      <= S_IDLE;
         fetch_req_q  <= 1'b0;
         bytes_left_q <= 2'h0;
         opcode_q     <= 8'h00;
         operand_q    <= 16'h0000;
         dec_q        <= '0;
      end
      else
      begin
         unique case (state_q)
            S_IDLE:
            begin
               if (run_q)
               begin
                  state_q     <= S_OPCODE;
                  fetch_req_q <= 1'b1;
               end
            end
            S_OPCODE:
            begin
               if (accept)
               begin
                  opcode_q     <= fetch_data;
                  dec_q        <= dec_d;
                  operand_q    <= 16'h0000;
                  bytes_left_q <= dec_d.length - LEN_1;
                  state_q      <= (dec_d.length == LEN_1) ? S_EXEC : S_OPERAND;
                  fetch_req_q  <= (dec_d.length != LEN_1);
               end
            end
            S_OPERAND:
            begin
               if (accept)
               begin
                  operand_q    <= {operand_q[7:0], fetch_data};
                  bytes_left_q <= bytes_left_q - 2'h1;
                  if (bytes_left_q == 2'h1)
                  begin
                     state_q     <= S_EXEC;
                     fetch_req_q <= 1'b0;
                  end
               end
            end
            S_EXEC:
            begin
               if (retire)
               begin
                  state_q     <= run_q ? S_OPCODE : S_IDLE;
                  fetch_req_q <= run_q;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cyc_q <= 6'h00;
      end
      else if (state_q == S_OPCODE && accept)
      begin
         cyc_q <= 6'h01;
      end
      else if (cyc_q != CYC_MAX)
      begin
         cyc_q <= cyc_q + 6'h01;
      end
   end

   // Program counter; software may move it only while the sequencer is idle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fetch_addr_q <= RST_PC;
      end
      else if (accept)
      begin
         fetch_addr_q <= fetch_addr_q + 16'h0001;
      end
      else if (wr_en && idx == IDX_PC && state_q == S_IDLE)
      begin
         if (pstrb[0])
         begin
            fetch_addr_q[7:0] <= pwdata[7:0];
         end
         if (pstrb[1])
         begin
            fetch_addr_q[15:8] <= pwdata[15:8];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         insn_valid_q   <= 1'b0;
         insn_opcode_q  <= 8'h00;
         insn_operand_q <= 16'h0000;
         insn_dec_q     <= '0;
      end
      else
      begin
         insn_valid_q <= retire;
         if (retire)
         begin
            insn_opcode_q  <= opcode_q;
            insn_operand_q <= operand_q;
            insn_dec_q     <= dec_q;
         end
      end
   end

endmodule : cid_decoder

// ### dv/cid_decoder_assertions.sv
// Purpose: Port-level checks of decoded instruction timing and fields.
// Assumes: One clock pclk, reset presetn active low.
// Notes: The gap counter saturates so that long idle stretches never wrap.
`timescale 1ns/1ps
module cid_decoder_checker
   import cid_pkg::*;
(
   // Clock and reset.
   input wire logic           pclk,
   input wire logic           presetn,
   // APB handshake.
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pready_q,
   // Retired instruction.
   input wire logic           insn_valid_q,
   input wire logic [7:0]     insn_opcode_q,
   input wire cid_decode_type insn_dec_q
);
   logic [5:0] gap_q;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_q <= 6'h3F;
      else if (insn_valid_q)
         gap_q <= 6'h01;
      else if (gap_q != 6'h3F)
         gap_q <= gap_q + 6'h01;
   end

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wait;
      psel && penable && !pready_q;
   endsequence
   property p_apb_answer;
      s_setup ##1 s_wait |=> pready_q ##1 !pready_q;
   endproperty
   property p_length;
      insn_valid_q |-> insn_dec_q.length inside {2'h1, 2'h2, 2'h3};
   endproperty
   property p_spacing;
      insn_valid_q |-> gap_q >= insn_dec_q.cycles && gap_q > insn_dec_q.length;
   endproperty
   property p_reg_num;
      insn_valid_q && insn_opcode_q[7:3] inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0B,
         5'h0D, 5'h0F, 5'h11, 5'h13, 5'h15, 5'h19, 5'h1D, 5'h1F}
      |-> insn_dec_q.reg_num == insn_opcode_q[2:0];
   endproperty
   property p_addr_top;
      insn_valid_q && insn_opcode_q[4:0] == 5'h11
      |-> insn_dec_q.addr_top == insn_opcode_q[7:5] && insn_dec_q.length == 2'h2;
   endproperty
   property p_mul;
      insn_valid_q && insn_opcode_q == 8'hA4 |-> insn_dec_q.cycles inside {6'h08, 6'h10};
   endproperty
   property p_div;
      insn_valid_q && insn_opcode_q == 8'h84
      |-> insn_dec_q.cycles inside {6'h08, 6'h10, 6'h20};
   endproperty
   property p_three_byte;
      insn_valid_q && insn_opcode_q inside {8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90}
      |-> insn_dec_q.length == 2'h3 && insn_dec_q.cycles == 6'h04;
   endproperty

   a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
   a_length:     assert property (p_length) else $error("bad length");
   a_spacing:    assert property (p_spacing) else $error("retire too soon");
   a_reg_num:    assert property (p_reg_num) else $error("bad reg num");
   a_addr_top:   assert property (p_addr_top) else $error("bad addr top");
   a_mul:        assert property (p_mul) else $error("bad mul cycles");
   a_div:        assert property (p_div) else $error("bad div cycles");
   a_three_byte: assert property (p_three_byte) else $error("bad long form");
endmodule : cid_decoder_checker

bind cid_decoder cid_decoder_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready_q(pready_q), .insn_valid_q(insn_valid_q),
   .insn_opcode_q(insn_opcode_q), .insn_dec_q(insn_dec_q));

// ### dv/test_cid_decoder.sv
// Purpose: Self-checking bench for the instruction decoder.
// Assumes: Program memory answers in the same cycle; APB master waits for pready.
// Notes: Table entries pack opcode, length and cycle count into one word.
`timescale 1ns/1ps
module test_cid_decoder
   import cid_pkg::*;
;
   logic                pclk = 1'b0;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [ADDR_W-1:0]   paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata_q;
   logic                pready_q;
   logic                pslverr_q;
   logic                fetch_req_q;
   logic [15:0]         fetch_addr_q;
   logic                fetch_valid;
   logic [7:0]          fetch_data;
   logic                insn_valid_q;
   logic [7:0]          insn_opcode_q;
   logic [15:0]         insn_operand_q;
   cid_decode_type      insn_dec_q;
   logic [7:0]          mem [0:255];
   logic [15:0]         prog [$];
   logic                stall_on;
   int                  cyc_n = 0;
   int                  checks = 0;
   int                  n_mismatch = 0;

   cid_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata_q(prdata_q),
      .pready_q(pready_q), .pslverr_q(pslverr_q), .fetch_req_q(fetch_req_q),
      .fetch_addr_q(fetch_addr_q), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
      .insn_valid_q(insn_valid_q), .insn_opcode_q(insn_opcode_q),
      .insn_operand_q(insn_operand_q), .insn_dec_q(insn_dec_q));

   assign fetch_data = mem[fetch_addr_q[7:0]];

   always #50 pclk = ~pclk;

   // The stall pattern withholds fetch_valid one cycle in four to stretch opcode and operand fetches.
   always @(posedge pclk)
   begin
      fetch_valid <= !stall_on || cyc_n[0] || cyc_n[1];
      cyc_n       <= cyc_n + 1;
   end

   task automatic wrap_up();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n       = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready_q !== 1'b1);
      rd  = prdata_q;
      err = pslverr_q;
      chk(n, 32'd2);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Loads the queued program, runs it and checks every retirement in order.
   task automatic run_prog(input logic stall);
      logic [31:0] rd;
      logic        err;
      logic [1:0]  ln;
      logic [5:0]  cy;
      int          a;
      int          t;
      int          last;
      a = 0;
      foreach (prog[i])
      begin
         mem[a] = prog[i][15:8];
         for (int b = 1; b < prog[i][7:6]; b++)
            mem[a + b] = 8'hA0 | b[7:0];
         a += prog[i][7:6];
      end
      stall_on <= stall;
      apb(1'b1, IDX_PC, 32'h0, rd, err);
      chk(fetch_addr_q, 32'h0);
      apb(1'b1, IDX_CTRL, 32'h1, rd, err);
      last = 0;
      foreach (prog[i])
      begin
         ln = prog[i][7:6];
         cy = prog[i][5:0];
         t  = 0;
         do
         begin
            @(posedge pclk);
            t++;
         end
         while (insn_valid_q !== 1'b1 && t < 100);
         chk(insn_valid_q, 1'b1);
         chk(insn_opcode_q, prog[i][15:8]);
         chk(insn_dec_q.length, ln);
         chk(insn_dec_q.cycles, cy);
         chk(insn_dec_q.illegal, 1'b0);
         if (ln == 2'h3)
            chk(insn_operand_q, 16'hA1A2);
         else if (ln == 2'h2)
            chk(insn_operand_q[7:0], 8'hA1);
         if (i > 0 && !stall)
            chk(cyc_n - last, (cy > ln) ? cy : ln + 1);
         last = cyc_n;
      end
      apb(1'b1, IDX_CTRL, 32'h0, rd, err);
      t = 0;
      do
      begin
         apb(1'b0, IDX_STATUS, 32'h0, rd, err);
         t++;
      end
      while (rd[ST_BUSY_BIT] !== 1'b0 && t < 50);
      chk(rd[ST_BUSY_BIT], 1'b0);
      chk(fetch_req_q, 1'b0);
      stall_on <= 1'b0;
      prog.delete();
   endtask : run_prog

   task automatic t_regs();
      logic [31:0] rd;
      logic        err;
      apb(1'b0, IDX_MD_OPERAND, 32'h0, rd, err);
      chk(rd, 32'h00000000);
      apb(1'b1, IDX_MD_OPERAND, 32'hFFFFFF5A, rd, err);
      apb(1'b0, IDX_MD_OPERAND, 32'h0, rd, err);
      chk({err, rd}, {1'b0, 32'h0000005A});
      apb(1'b0, IDX_CFG_LOW, 32'h0, rd, err);
      chk(rd, 32'h00000000);
      apb(1'b0, 8'h10, 32'h0, rd, err);
      chk({err, rd}, {1'b1, 32'h00000000});
   endtask : t_regs

   task automatic t_table();
      prog = {prog, 16'h2F42, 16'h2582, 16'h2642, 16'h2482};
      prog = {prog, 16'h3842, 16'h3582, 16'h3742, 16'h3482};
      prog = {prog, 16'h9B42, 16'h9582, 16'h9642, 16'h9482};
      prog = {prog, 16'h5C42, 16'h5582, 16'h5742, 16'h5482, 16'h5282, 16'h53C4};
      prog = {prog, 16'h4942, 16'h4582, 16'h4642, 16'h4482, 16'h4282, 16'h43C4};
      prog = {prog, 16'h6E42, 16'h6582, 16'h6742, 16'h6482, 16'h6282, 16'h63C4};
      prog = {prog, 16'h2342, 16'h3342, 16'h0342, 16'h1342, 16'hE442, 16'hF442};
      prog = {prog, 16'hC442, 16'hE842, 16'hE582, 16'hE642, 16'h7482};
      prog = {prog, 16'hFD42, 16'hAA84, 16'h7B82};
      prog = {prog, 16'hF582, 16'h8984, 16'h85C4, 16'h8684, 16'h75C4};
      prog = {prog, 16'hF642, 16'h7782, 16'hA784};
      prog = {prog, 16'h90C4, 16'h9344, 16'h8344};
      prog = {prog, 16'hE244, 16'hE344, 16'hE044, 16'hF244, 16'hF044};
      prog = {prog, 16'hC084, 16'hD084};
      prog = {prog, 16'hCB42, 16'hC582, 16'hC742, 16'hD642, 16'hD742};
      prog = {prog, 16'h1184, 16'hF184};
      run_prog(1'b0);
   endtask : t_table

   task automatic t_stall();
      prog = {16'h85C4, 16'h2482, 16'h0342, 16'h90C4, 16'hD084};
      run_prog(1'b1);
   endtask : t_stall

   task automatic t_muldiv();
      logic [31:0] rd;
      logic        err;
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, IDX_CFG_LOW, {28'h0, m[1], 2'b00, m[0]}, rd, err);
         prog = {m[0] ? 16'hA450 : 16'hA448};
         prog = {prog, !m[0] ? 16'h8448 : (m[1] ? 16'h8460 : 16'h8450)};
         run_prog(1'b0);
      end
      apb(1'b1, IDX_CFG_LOW, 32'h0, rd, err);
   endtask : t_muldiv

   initial
   begin
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = '0;
      pwdata      = 32'h0;
      stall_on    = 1'b0;
      foreach (mem[i])
         mem[i] = 8'h00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // A hung handshake is cut off by the cycle ceiling and counted as a mismatch.
      fork
         begin
            t_regs();
            t_table();
            t_stall();
            t_muldiv();
         end
         begin
            wait (cyc_n == 20000);
            n_mismatch++;
         end
      join_any
      wrap_up();
   end
endmodule : test_cid_decoder
